// ---- cdec_pkg.sv ----
// Shared constants and carrier types for the compressed halfword decoder
package cdec_pkg;

	// Native condition field values
	localparam logic [3:0]  BRANCH_CONDITION_FIELD_AL      = 4'hE;
	localparam logic [3:0]  BRANCH_CONDITION_FIELD_RSV     = 4'hE;

	// Native data processing opcodes
	localparam logic [3:0]  DP_AND       = 4'h0;
	localparam logic [3:0]  DP_EOR       = 4'h1;
	localparam logic [3:0]  DP_SUB       = 4'h2;
	localparam logic [3:0]  DP_RSB       = 4'h3;
	localparam logic [3:0]  DP_ADD       = 4'h4;
	localparam logic [3:0]  DP_ADC       = 4'h5;
	localparam logic [3:0]  DP_SBC       = 4'h6;
	localparam logic [3:0]  DP_TST       = 4'h8;
	localparam logic [3:0]  DP_CMP       = 4'hA;
	localparam logic [3:0]  DP_CMN       = 4'hB;
	localparam logic [3:0]  DP_ORR       = 4'hC;
	localparam logic [3:0]  DP_MOV       = 4'hD;
	localparam logic [3:0]  DP_BIC       = 4'hE;
	localparam logic [3:0]  DP_MVN       = 4'hF;

	// Shift types in the native operand field
	localparam logic [1:0]  SH_LSL       = 2'h0;
	localparam logic [1:0]  SH_LSR       = 2'h1;
	localparam logic [1:0]  SH_ASR       = 2'h2;
	localparam logic [1:0]  SH_ROR       = 2'h3;

	// Halfword transfer type bits
	localparam logic [1:0]  HT_UHALF     = 2'h1;

	// Special registers
	localparam logic [3:0]  REG_SP       = 4'hD;
	localparam logic [3:0]  REG_PC       = 4'hF;

	// Rotate code giving a left shift by two of an 8-bit immediate
	localparam logic [3:0]  ROT_LSL2     = 4'hF;

	// Fixed native words and field tags
	localparam logic [27:0] BX_BODY      = 28'h12FFF10;
	localparam logic [3:0]  MUL_TAG      = 4'h9;
	localparam logic [3:0]  SWI_TAG      = 4'hF;
	localparam logic [3:0]  BR_TAG       = 4'hA;
	localparam logic [3:0]  BRL_TAG      = 4'hB;
	localparam logic [31:0] NATIVE_NONE  = 32'h00000000;

	// One-hot encoding formats, zero when nothing matches
	typedef enum logic [19:0] {
		FMT_NONE    = 20'h00000,
		FMT_SHIFT   = 20'h00001,
		FMT_ADDSUB  = 20'h00002,
		FMT_IMM     = 20'h00004,
		FMT_ALU     = 20'h00008,
		FMT_HIREG   = 20'h00010,
		FMT_PCLOAD  = 20'h00020,
		FMT_LSREG   = 20'h00040,
		FMT_LSSIGN  = 20'h00080,
		FMT_LSIMM   = 20'h00100,
		FMT_LSHALF  = 20'h00200,
		FMT_SPLS    = 20'h00400,
		FMT_ADDR    = 20'h00800,
		FMT_SPADJ   = 20'h01000,
		FMT_PUSHPOP = 20'h02000,
		FMT_MULTI   = 20'h04000,
		FMT_BCOND   = 20'h08000,
		FMT_SWI     = 20'h10000,
		FMT_BUNC    = 20'h20000,
		FMT_BLINK   = 20'h40000
	} cdec_fmt_t;

	// Extracted fields; rs also carries the base register of transfers
	typedef struct packed {
		logic [3:0]  op;
		logic [3:0]  rd;
		logic [3:0]  rs;
		logic [3:0]  rn;
		logic [10:0] imm;
		logic [7:0]  register_list_field;
		logic        link_bit;
	} cdec_fields_t;

	// Decoder result towards the native pipeline
	typedef struct packed {
		logic         valid;
		logic [31:0]  native;
		cdec_fmt_t    fmt;
		cdec_fields_t fld;
		logic         sets_flags;
		logic         undefined;
	} cdec_out_t;

endpackage : cdec_pkg

// ---- cdec_sort.sv ----
// Format sorting and field extraction for one compressed halfword
`timescale 1ns/1ps
`default_nettype none
module cdec_sort import cdec_pkg::*; (
	// Halfword in
	input  wire logic [15:0] half,
	// Format and fields out
	output cdec_fmt_t        fmt,
	output cdec_fields_t     fld
);

	// Priority order matters: sub-patterns are tested before their parents
	function automatic cdec_fmt_t classify(input logic [15:0] h);
		if (h[15:11] == 5'h03)
			return FMT_ADDSUB;
		else if (h[15:13] == 3'h0)
			return FMT_SHIFT;
		else if (h[15:13] == 3'h1)
			return FMT_IMM;
		else if (h[15:10] == 6'h10)
			return FMT_ALU;
		else if (h[15:10] == 6'h11)
			return FMT_HIREG;
		else if (h[15:11] == 5'h09)
			return FMT_PCLOAD;
		else if (h[15:12] == 4'h5)
			return h[9] ? FMT_LSSIGN : FMT_LSREG;
		else if (h[15:13] == 3'h3)
			return FMT_LSIMM;
		else if (h[15:12] == 4'h8)
			return FMT_LSHALF;
		else if (h[15:12] == 4'h9)
			return FMT_SPLS;
		else if (h[15:12] == 4'hA)
			return FMT_ADDR;
		else if (h[15:8] == 8'hB0)
			return FMT_SPADJ; // RL4
		else if (h[15:12] == 4'hB && h[10:9] == 2'h2)
			return FMT_PUSHPOP;
		else if (h[15:12] == 4'hC)
			return FMT_MULTI;
		else if (h[15:8] == 8'hDF)
			return FMT_SWI;
		else if (h[15:12] == 4'hD)
			return FMT_BCOND;
		else if (h[15:11] == 5'h1C)
			return FMT_BUNC;
		else if (h[15:12] == 4'hF)
			return FMT_BLINK;
		else
			return FMT_NONE; // RL13
	endfunction : classify

	// Low register fields reach only registers 0 to 7
	function automatic logic [3:0] lo(input logic [2:0] r);
		return {1'b0, r}; // RL12
	endfunction : lo

	assign fmt = classify(half); // RL3

	always_comb begin // RL1
		fld = '0;
		unique case (fmt)
			FMT_SHIFT, FMT_LSIMM, FMT_LSHALF: begin
				fld.op  = {2'h0, half[12:11]};
				fld.imm = {6'h00, half[10:6]};
				fld.rs  = lo(half[5:3]);
				fld.rd  = lo(half[2:0]);
			end
			FMT_ADDSUB, FMT_LSREG, FMT_LSSIGN: begin
				fld.op  = {2'h0, half[11:10]};
				if (fmt == FMT_ADDSUB)
					fld.op = {2'h0, half[10:9]};
				fld.rn  = lo(half[8:6]);
				fld.imm = {8'h00, half[8:6]};
				fld.rs  = lo(half[5:3]);
				fld.rd  = lo(half[2:0]);
			end
			FMT_IMM, FMT_PCLOAD, FMT_SPLS, FMT_ADDR: begin
				fld.op  = {2'h0, half[12:11]};
				fld.rd  = lo(half[10:8]);
				fld.imm = {3'h0, half[7:0]};
			end
			FMT_ALU: begin
				fld.op = half[9:6]; // RL11
				fld.rs = lo(half[5:3]);
				fld.rd = lo(half[2:0]);
			end
			FMT_HIREG: begin
				fld.op = {2'h0, half[9:8]};
				fld.rd = {half[7], half[2:0]}; // RL12
				fld.rs = {half[6], half[5:3]}; // RL12
			end
			FMT_SPADJ: begin
				fld.op  = {3'h0, half[7]}; // RL4
				fld.imm = {4'h0, half[6:0]};
			end
			FMT_PUSHPOP, FMT_MULTI: begin
				fld.op                  = {3'h0, half[11]};
				fld.link_bit            = half[8];
				fld.rs                  = lo(half[10:8]);
				fld.register_list_field = half[7:0];
			end
			FMT_BCOND, FMT_SWI: begin
				fld.op  = half[11:8];
				fld.imm = {3'h0, half[7:0]};
			end
			FMT_BUNC, FMT_BLINK: begin
				fld.op  = {3'h0, half[11]}; // RL5
				fld.imm = half[10:0];
			end
			FMT_NONE: begin
				fld = '0;
			end
			default: begin
				fld = '0;
			end
		endcase
	end

endmodule : cdec_sort
`default_nettype wire

// ---- cdec_expand.sv ----
// Compressed halfword decoder: expansion to native operations
//
// How it works
// RL1 - Take each instruction as one 16-bit word
// RL2 - Emit the equivalent 32-bit native operation
// RL3 - Sort into nineteen formats by leading bits
// RL4 - Stack adjust: sign bit selects add/subtract
// RL5 - Long call halves joined by high/low bit
// RL6 - Add sets flags only in low forms
// RL7 - Move sets flags except high-register move
// RL8 - ALU ops set flags; transfers, branches never
// RL9 - Shift move ops: left, logical, arithmetic
// RL10 - Immediate ops: move, compare, add, subtract
// RL11 - ALU field decodes sixteen listed operations
// RL12 - Low fields 0-7; high selects give 8-15
// RL13 - Unmatched encodings flagged undefined
`timescale 1ns/1ps
`default_nettype none
module cdec_expand import cdec_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// From fetch
	input  wire logic        in_valid,
	input  wire logic [15:0] in_half,
	input  wire logic        flush,
	// To native pipeline
	output cdec_out_t        out
);

	typedef struct packed {
		cdec_out_t   res;
		logic        bl_pend;
		logic [10:0] bl_high;
	} cdec_state_t;

	cdec_state_t  q;
	cdec_state_t  d;
	cdec_fmt_t    fmt;
	cdec_fields_t f;

	cdec_sort u_sort (
		.half (in_half),
		.fmt  (fmt),
		.fld  (f)
	);

	function automatic logic [31:0] dp(input logic [3:0] opc,
		input logic s, input logic i, input logic [3:0] rn,
		input logic [3:0] rd, input logic [11:0] op2);
		return {BRANCH_CONDITION_FIELD_AL, 2'h0, i, opc, s, rn, rd, op2};
	endfunction : dp

	function automatic logic [31:0] ls(input logic i, input logic b,
		input logic l, input logic [3:0] rn, input logic [3:0] rd,
		input logic [11:0] off);
		return {BRANCH_CONDITION_FIELD_AL, 2'h1, i, 1'b1, 1'b1, b, 1'b0, l, rn, rd, off};
	endfunction : ls

	function automatic logic [31:0] lsh(input logic i, input logic l,
		input logic [1:0] sh, input logic [3:0] rn, input logic [3:0] rd,
		input logic [7:0] off);
		return {BRANCH_CONDITION_FIELD_AL, 3'h0, 1'b1, 1'b1, i, 1'b0, l, rn, rd, off[7:4],
			1'b1, sh, 1'b1, off[3:0]};
	endfunction : lsh

	function automatic logic [31:0] blk(input logic p, input logic u,
		input logic l, input logic [3:0] rn, input logic [15:0] list);
		return {BRANCH_CONDITION_FIELD_AL, 3'h4, p, u, 1'b0, 1'b1, l, rn, list};
	endfunction : blk

	always_comb begin
		logic [3:0] opc;
		logic [1:0] sh;
		logic       flag;
		logic       und;
		logic       emit;
		logic [31:0] nat;
		opc  = DP_AND;
		sh   = SH_LSL;
		flag = 1'b0;
		und  = 1'b0;
		emit = in_valid;
		nat  = NATIVE_NONE;
		d    = q;
		unique case (fmt)
			FMT_SHIFT: begin
				// Op 11 never lands here, it belongs to add/subtract
				nat  = dp(DP_MOV, 1'b1, 1'b0, 4'h0, f.rd,
					{f.imm[4:0], f.op[1:0], 1'b0, f.rs}); // RL9
				flag = 1'b1; // RL8
			end
			FMT_ADDSUB: begin
				opc  = f.op[0] ? DP_SUB : DP_ADD;
				nat  = dp(opc, 1'b1, f.op[1], f.rs, f.rd,
					f.op[1] ? {9'h000, f.imm[2:0]} : {8'h00, f.rn});
				flag = 1'b1; // RL6
			end
			FMT_IMM: begin
				unique case (f.op[1:0])
					2'h0: nat = dp(DP_MOV, 1'b1, 1'b1, 4'h0, f.rd,
						{4'h0, f.imm[7:0]}); // RL10
					2'h1: nat = dp(DP_CMP, 1'b1, 1'b1, f.rd, 4'h0,
						{4'h0, f.imm[7:0]}); // RL10
					2'h2: nat = dp(DP_ADD, 1'b1, 1'b1, f.rd, f.rd,
						{4'h0, f.imm[7:0]}); // RL10
					2'h3: nat = dp(DP_SUB, 1'b1, 1'b1, f.rd, f.rd,
						{4'h0, f.imm[7:0]}); // RL10
				endcase
				flag = 1'b1; // RL7
			end
			FMT_ALU: begin
				flag = 1'b1; // RL8
				unique case (f.op)
					4'h0: opc = DP_AND;
					4'h1: opc = DP_EOR;
					4'h5: opc = DP_ADC;
					4'h6: opc = DP_SBC;
					4'h8: opc = DP_TST;
					4'hA: opc = DP_CMP;
					4'hB: opc = DP_CMN;
					4'hC: opc = DP_ORR;
					4'hE: opc = DP_BIC;
					4'hF: opc = DP_MVN;
					4'h3: sh = SH_LSR;
					4'h4: sh = SH_ASR;
					4'h7: sh = SH_ROR;
					default: sh = SH_LSL;
				endcase
				unique case (f.op)
					4'h2, 4'h3, 4'h4, 4'h7: nat = dp(DP_MOV, 1'b1, 1'b0,
						4'h0, f.rd, {f.rs, 1'b0, sh, 1'b1, f.rd}); // RL11
					4'h9: nat = dp(DP_RSB, 1'b1, 1'b1, f.rs, f.rd,
						12'h000); // RL11
					4'hD: nat = {BRANCH_CONDITION_FIELD_AL, 7'h00, 1'b1, f.rd, 4'h0, f.rd,
						MUL_TAG, f.rs}; // RL11
					4'h8, 4'hA, 4'hB: nat = dp(opc, 1'b1, 1'b0, f.rd, 4'h0,
						{8'h00, f.rs}); // RL11
					4'hF: nat = dp(opc, 1'b1, 1'b0, 4'h0, f.rd,
						{8'h00, f.rs}); // RL11
					default: nat = dp(opc, 1'b1, 1'b0, f.rd, f.rd,
						{8'h00, f.rs}); // RL11
				endcase
			end
			FMT_HIREG: begin
				unique case (f.op[1:0])
					2'h0: nat = dp(DP_ADD, 1'b0, 1'b0, f.rd, f.rd,
						{8'h00, f.rs}); // RL6
					2'h1: nat = dp(DP_CMP, 1'b1, 1'b0, f.rd, 4'h0,
						{8'h00, f.rs});
					2'h2: nat = dp(DP_MOV, 1'b0, 1'b0, 4'h0, f.rd,
						{8'h00, f.rs}); // RL7
					2'h3: nat = {BRANCH_CONDITION_FIELD_AL, BX_BODY[27:4], f.rs}; // RL8
				endcase
				flag = (f.op[1:0] == 2'h1);
				// Both selects clear outside exchange, or a high target on exchange, is illegal
				und  = (f.op[1:0] == 2'h3) ? f.rd[3] :
					!(f.rd[3] | f.rs[3]); // RL13
			end
			FMT_PCLOAD:
				nat = ls(1'b0, 1'b0, 1'b1, REG_PC, f.rd,
					{2'h0, f.imm[7:0], 2'h0}); // RL8
			FMT_LSREG:
				nat = ls(1'b1, f.op[0], f.op[1], f.rs, f.rd,
					{8'h00, f.rn});
			FMT_LSSIGN: begin
				sh  = f.op[0] ? {1'b1, f.op[1]} : HT_UHALF;
				nat = lsh(1'b0, f.op[1] | f.op[0], sh, f.rs, f.rd,
					{4'h0, f.rn});
			end
			FMT_LSIMM:
				nat = ls(1'b0, f.op[1], f.op[0], f.rs, f.rd, f.op[1] ?
					{7'h00, f.imm[4:0]} : {5'h00, f.imm[4:0], 2'h0});
			FMT_LSHALF:
				nat = lsh(1'b1, f.op[0], HT_UHALF, f.rs, f.rd,
					{2'h0, f.imm[4:0], 1'b0});
			FMT_SPLS:
				nat = ls(1'b0, 1'b0, f.op[0], REG_SP, f.rd,
					{2'h0, f.imm[7:0], 2'h0});
			FMT_ADDR:
				nat = dp(DP_ADD, 1'b0, 1'b1, f.op[0] ? REG_SP : REG_PC,
					f.rd, {ROT_LSL2, f.imm[7:0]}); // RL6
			FMT_SPADJ:
				nat = dp(f.op[0] ? DP_SUB : DP_ADD, 1'b0, 1'b1, REG_SP,
					REG_SP, {ROT_LSL2, 1'b0, f.imm[6:0]}); // RL4
			FMT_PUSHPOP:
				// Push adds the link register, pop adds the program counter
				nat = f.op[0] ?
					blk(1'b0, 1'b1, 1'b1, REG_SP, {f.link_bit, 7'h00,
						f.register_list_field}) :
					blk(1'b1, 1'b0, 1'b0, REG_SP, {1'b0, f.link_bit, 6'h00,
						f.register_list_field}); // RL8
			FMT_MULTI:
				nat = blk(1'b0, 1'b1, f.op[0], f.rs,
					{8'h00, f.register_list_field}); // RL8
			FMT_BCOND: begin
				nat = {f.op, BR_TAG, {16{f.imm[7]}}, f.imm[7:0]};
				und = (f.op == BRANCH_CONDITION_FIELD_RSV); // RL13
			end
			FMT_SWI:
				nat = {BRANCH_CONDITION_FIELD_AL, SWI_TAG, 16'h0000, f.imm[7:0]}; // RL8
			FMT_BUNC:
				nat = {BRANCH_CONDITION_FIELD_AL, BR_TAG, {13{f.imm[10]}}, f.imm}; // RL8
			FMT_BLINK: begin
				if (!f.op[0]) begin
					// First half is held back, only the pair leaves
					emit = 1'b0; // RL5
					if (in_valid) begin
						d.bl_pend = 1'b1; // RL5
						d.bl_high = f.imm;
					end
				end else begin
					nat = {BRANCH_CONDITION_FIELD_AL, BRL_TAG, {2{q.bl_high[10]}}, q.bl_high,
						f.imm}; // RL5
					und = !q.bl_pend; // RL13
					if (in_valid)
						d.bl_pend = 1'b0;
				end
			end
			FMT_NONE:
				und = 1'b1; // RL13
			default:
				und = 1'b1;
		endcase
		// Any other halfword breaks a pending call pair
		if (in_valid && fmt != FMT_BLINK)
			d.bl_pend = 1'b0;
		if (und)
			nat = NATIVE_NONE;
		d.res.valid      = emit && !flush;
		d.res.native     = nat; // RL2
		d.res.fmt        = fmt;
		d.res.fld        = f;
		d.res.sets_flags = flag && !und;
		d.res.undefined  = und;
		if (flush)
			d.bl_pend = 1'b0;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			q <= '0;
		else
			q <= d;
	end

	assign out = q.res;

endmodule : cdec_expand
`default_nettype wire

// ---- cdec_chk.sv ----
// Port checks for the compressed halfword decoder
`timescale 1ns/1ps
`default_nettype none
module cdec_chk import cdec_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// From fetch
	input  wire logic        in_valid,
	input  wire logic [15:0] in_half,
	input  wire logic        flush,
	// To native pipeline
	input  wire cdec_out_t   out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Accepted and not flushed
	wire logic take = in_valid && !flush;

	chk_answer_lat:
	assert property (take && in_half[15:11] != 5'h1E |=> out.valid)
		else $error("accepted halfword gave no result");
	chk_idle_quiet:
	assert property (!in_valid || flush |=> !out.valid)
		else $error("result without accepted halfword");
	chk_call_first:
	assert property (take && in_half[15:11] == 5'h1E |=> !out.valid)
		else $error("first call half gave a result");
	chk_imm_fmt:
	assert property (take && in_half[15:13] == 3'h1 |=>
		out.fmt == FMT_IMM && out.sets_flags)
		else $error("immediate format or flags wrong");
	chk_alu_op:
	assert property (take && in_half[15:10] == 6'h10 |=> out.fmt == FMT_ALU
		&& out.sets_flags && out.fld.op == $past(in_half[9:6]))
		else $error("alu operation decode wrong");
	chk_hi_noflag:
	assert property (take && in_half[15:10] == 6'h11 && in_half[9:8] != 2'h1
		|=> !out.sets_flags)
		else $error("high register op set flags");
	chk_spadj_sign:
	assert property (take && in_half[15:8] == 8'hB0 |=> !out.sets_flags &&
		out.native[24:21] == ($past(in_half[7]) ? DP_SUB : DP_ADD))
		else $error("stack adjust direction wrong");
	chk_low_regs:
	assert property (take && in_half[15:13] == 3'h0 |=>
		out.fld.rd == {1'b0, $past(in_half[2:0])})
		else $error("low destination register wrong");
	chk_xfer_noflag:
	assert property (take && in_half[15:12] >= 4'h5 |=>
		!(out.valid && out.sets_flags))
		else $error("transfer or branch set flags");
	chk_branch_condition_field_rsv:
	assert property (take && in_half[15:8] == 8'hDE |=> out.undefined)
		else $error("reserved branch condition accepted");
	chk_undef_zero:
	assert property (out.valid && out.undefined |-> out.native == NATIVE_NONE)
		else $error("undefined result carries a native word");
	chk_fmt_onehot:
	assert property (out.valid && !out.undefined |-> $onehot(out.fmt))
		else $error("format not one-hot");
endmodule : cdec_chk
`default_nettype wire

// ---- cdec_sink.sv ----
// Native pipeline stand-in that counts delivered operations
`timescale 1ns/1ps
`default_nettype none
module cdec_sink import cdec_pkg::*; (
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      reset,
	// Decoder result
	input  wire cdec_out_t res,
	// Delivered count
	output var int         seen
);
	// Takes a result only in its one valid cycle, as the pipeline would
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			seen <= 0;
		else if (res.valid)
			seen <= seen + 1;
	end
endmodule : cdec_sink
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the compressed halfword decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top import cdec_pkg::*; ;
	typedef struct packed {
		logic [15:0] h;
		cdec_fmt_t   f;
		logic [2:0]  c;
		logic [31:0] w;
	} cdec_row_t;
	// Row flags: bit 2 sets flags, bit 1 undefined, bit 0 native known
	cdec_row_t rows[$] = '{
		'{16'h0088, FMT_SHIFT,   3'h5, 32'hE1B00101},
		'{16'h0888, FMT_SHIFT,   3'h5, 32'hE1B00121},
		'{16'h1088, FMT_SHIFT,   3'h5, 32'hE1B00141},
		'{16'h1888, FMT_ADDSUB,  3'h4, 32'h00000000},
		'{16'h2080, FMT_IMM,     3'h5, 32'hE3B00080},
		'{16'h2880, FMT_IMM,     3'h5, 32'hE3500080},
		'{16'h3080, FMT_IMM,     3'h5, 32'hE2900080},
		'{16'h3880, FMT_IMM,     3'h5, 32'hE2500080},
		'{16'h4488, FMT_HIREG,   3'h1, 32'hE0888001},
		'{16'h4588, FMT_HIREG,   3'h4, 32'h00000000},
		'{16'h4688, FMT_HIREG,   3'h1, 32'hE1A08001},
		'{16'h4708, FMT_HIREG,   3'h1, 32'hE12FFF11},
		'{16'h4801, FMT_PCLOAD,  3'h0, 32'h00000000},
		'{16'h5000, FMT_LSREG,   3'h0, 32'h00000000},
		'{16'h5200, FMT_LSSIGN,  3'h0, 32'h00000000},
		'{16'h6000, FMT_LSIMM,   3'h0, 32'h00000000},
		'{16'h8000, FMT_LSHALF,  3'h0, 32'h00000000},
		'{16'h9000, FMT_SPLS,    3'h0, 32'h00000000},
		'{16'hA000, FMT_ADDR,    3'h0, 32'h00000000},
		'{16'hB001, FMT_SPADJ,   3'h1, 32'hE28DDF01},
		'{16'hB081, FMT_SPADJ,   3'h1, 32'hE24DDF01},
		'{16'hB401, FMT_PUSHPOP, 3'h0, 32'h00000000},
		'{16'hC001, FMT_MULTI,   3'h0, 32'h00000000},
		'{16'hD001, FMT_BCOND,   3'h1, 32'h0A000001},
		'{16'hDF00, FMT_SWI,     3'h0, 32'h00000000},
		'{16'hE001, FMT_BUNC,    3'h1, 32'hEA000001},
		'{16'hDE01, FMT_NONE,    3'h2, 32'h00000000},
		'{16'h4408, FMT_NONE,    3'h2, 32'h00000000},
		'{16'hE800, FMT_NONE,    3'h2, 32'h00000000},
		'{16'hB100, FMT_NONE,    3'h2, 32'h00000000},
		'{16'h4008, FMT_ALU,     3'h5, 32'hE0100001},
		'{16'h4048, FMT_ALU,     3'h5, 32'hE0300001},
		'{16'h4088, FMT_ALU,     3'h5, 32'hE1B00110},
		'{16'h40C8, FMT_ALU,     3'h5, 32'hE1B00130},
		'{16'h4108, FMT_ALU,     3'h5, 32'hE1B00150},
		'{16'h4148, FMT_ALU,     3'h5, 32'hE0B00001},
		'{16'h4188, FMT_ALU,     3'h5, 32'hE0D00001},
		'{16'h41C8, FMT_ALU,     3'h5, 32'hE1B00170},
		'{16'h4208, FMT_ALU,     3'h5, 32'hE1100001},
		'{16'h4248, FMT_ALU,     3'h5, 32'hE2710000},
		'{16'h4288, FMT_ALU,     3'h5, 32'hE1500001},
		'{16'h42C8, FMT_ALU,     3'h5, 32'hE1700001},
		'{16'h4308, FMT_ALU,     3'h5, 32'hE1900001},
		'{16'h4348, FMT_ALU,     3'h5, 32'hE0100091},
		'{16'h4388, FMT_ALU,     3'h5, 32'hE1D00001},
		'{16'h43C8, FMT_ALU,     3'h5, 32'hE1F00001}
	};
	logic        clk;
	logic        reset;
	logic        in_valid;
	logic [15:0] in_half;
	logic        flush;
	cdec_out_t   out;
	int          seen;
	int          mismatches;
	int          num_checks;
	int          n;

	cdec_expand i_dut (.clk(clk), .reset(reset), .in_valid(in_valid),
		.in_half(in_half), .flush(flush), .out(out));
	cdec_sink i_sink (.clk(clk), .reset(reset), .res(out), .seen(seen));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_vec

	task automatic check_out(input cdec_row_t r);
		chk_vec({31'h0, out.valid}, 32'h1);
		chk_vec({31'h0, out.undefined}, {31'h0, r.c[1]});
		if (!r.c[1])
			chk_vec({12'h0, out.fmt}, {12'h0, r.f});
		if (!r.c[1])
			chk_vec({31'h0, out.sets_flags}, {31'h0, r.c[2]});
		if (r.c[0] || r.c[1])
			chk_vec(out.native, r.w);
	endtask : check_out

	// Drive at the falling edge so the rising edge sees settled inputs
	task automatic put(input logic v, input logic [15:0] h, input logic f);
		@(negedge clk);
		in_valid = v;
		in_half = h;
		flush = f;
	endtask : put

	task end_of_test;
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	initial begin
		mismatches = 0;
		num_checks = 0;
		reset = 1'b1;
		in_valid = 1'b0;
		in_half = 16'h0000;
		flush = 1'b0;
		repeat (20) @(negedge clk);
		chk_vec({31'h0, |out}, 32'h0);
		reset = 1'b0;
		// Back to back: each row checked while the next is taken
		n = rows.size();
		for (int i = 0; i <= n; i++) begin
			put(i < n, (i < n) ? rows[i % n].h : 16'h0000, 1'b0);
			if (i > 0)
				check_out(rows[i - 1]);
		end
		$display("Test rows done");
		put(1'b1, 16'hF000, 1'b0);
		put(1'b1, 16'hF801, 1'b0);
		chk_vec({31'h0, out.valid}, 32'h0);
		put(1'b1, 16'hF000, 1'b0);
		check_out('{16'hF801, FMT_BLINK, 3'h1, 32'hEB000001});
		// A halfword between the halves cancels the pair
		put(1'b1, 16'h2080, 1'b0);
		put(1'b1, 16'hF801, 1'b0);
		check_out(rows[4]);
		put(1'b1, 16'hF000, 1'b0);
		chk_vec({31'h0, out.undefined}, 32'h1);
		put(1'b1, 16'hF801, 1'b1);
		put(1'b1, 16'hF801, 1'b0);
		chk_vec({31'h0, out.valid}, 32'h0);
		put(1'b0, 16'h0000, 1'b0);
		chk_vec({31'h0, out.undefined}, 32'h1);
		put(1'b0, 16'h0000, 1'b0);
		chk_vec({31'h0, out.valid}, 32'h0);
		chk_vec(32'(seen), 32'(n + 4));
		$display("Test call done");
		put(1'b1, 16'h2080, 1'b0);
		@(negedge clk);
		reset = 1'b1;
		#1;
		chk_vec({31'h0, |out}, 32'h0);
		put(1'b0, 16'h0000, 1'b0);
		reset = 1'b0;
		put(1'b1, 16'hF801, 1'b0);
		put(1'b0, 16'h0000, 1'b0);
		chk_vec({31'h0, out.undefined}, 32'h1);
		$display("Test reset done");
		end_of_test();
	end

	// Run needs well under a microsecond
	initial begin
		#5000;
		mismatches++;
		end_of_test();
	end
endmodule : tb_top

bind cdec_expand cdec_chk i_chk (.clk(clk), .reset(reset),
	.in_valid(in_valid), .in_half(in_half), .flush(flush), .out(out));
`default_nettype wire
